/* hdl/isp_pkg.sv */
// isp_pkg: constants, carriers and state types of the serial programming port
// assumes a 10 MHz device clock and an external programmer driving sck, mosi and the reset pin
// Functional notes
// - programming only while reset pin held low
// - ignore work until enable instruction accepted
// - eeprom write auto-erases its location first
// - chip erase fills flash and eeprom with ff
// - separate flash and eeprom address spaces
// - mosi sampled on sck rising edge
// - miso shifted on sck falling edge
// - echo 53 during third enable byte
// - page load: six address bits, one byte
// - page write: seven page bits, whole page
// - eeprom written one byte per instruction
// - read instruction returns selected memory byte
// - reset high leaves programming mode
// - busy page reads ff until done
// - enable instruction is ac 53 x x
package isp_pkg;
   localparam int         CLK_HZ          = 10_000_000;
   localparam real        FLASH_WAIT_MS   = 14.0;
   localparam real        EEPROM_WAIT_MS  = 3.4;
   localparam int         FLASH_WAIT_CYC  = int'($ceil(FLASH_WAIT_MS * 1.0e-3 * CLK_HZ));
   localparam int         EEPROM_WAIT_CYC = int'($ceil(EEPROM_WAIT_MS * 1.0e-3 * CLK_HZ));
   localparam int         FLASH_AW        = 14;
   localparam int         EEPROM_AW       = 9;
   localparam int         PAGE_AW         = 7;
   localparam int         H_BIT           = 3;
   localparam logic [13:0] FLASH_LAST     = 14'h3FFF;
   localparam logic [13:0] PAGE_BYTES     = 14'h0080;
   localparam logic [4:0] EE_WALK_TOP     = 5'h00;
   localparam logic [7:0] ERASED          = 8'hFF;
   localparam logic [7:0] OP_ENABLE_B1    = 8'hAC;
   localparam logic [7:0] ENABLE_B2       = 8'h53;
   localparam logic [2:0] ERASE_B2_TOP    = 3'h4;
   localparam logic [7:0] OP_RD_FLASH     = 8'h20;
   localparam logic [7:0] OP_LD_PAGE      = 8'h40;
   localparam logic [7:0] OP_WR_PAGE      = 8'h4C;
   localparam logic [7:0] OP_RD_EE        = 8'hA0;
   localparam logic [7:0] OP_WR_EE        = 8'hC0;

   typedef struct packed {
      logic [7:0] data;
      logic       tgl;
   } isp_rx_t;

   typedef struct packed {
      logic [7:0] data;
      logic       use_it;
   } isp_tx_t;

   typedef enum {B_IDLE, B_ERASE, B_COPY, B_FLASH, B_EE} isp_busy_t;

   typedef struct packed {
      logic [2:0]  rn_sync;
      logic        in_reset;
      logic [2:0]  tg_sync;
      logic        tg_seen;
      logic [1:0]  idx;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [7:0]  b2;
      logic        prog_en;
      isp_busy_t   busy;
      logic        busy_o;
      logic [31:0] timer;
      logic [13:0] walk;
      logic [6:0]  page;
      logic [8:0]  ee_addr;
      logic [1:0]  rd_stage;
      logic        rd_ee;
      logic        rd_ff;
      isp_tx_t     tx;
   } isp_core_t;
endpackage

/* hdl/isp_mem.sv */
// isp_mem: byte-wide memory with one write port and one registered read port
// assumes writes and reads on the device clock; contents are undefined until written
`timescale 1ns/1ps
module isp_mem #(
   parameter int AW = 9
) (
   // clock
   input  wire logic          clk,
   // write side
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata,
   // read side
   input  wire logic [AW-1:0] raddr,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [0:(1 << AW) - 1];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

/* hdl/isp_link.sv */
// isp_link: sck-domain byte shifter of the serial programming port
// assumes sck stands still while the reset pin is high; the reply word is stable at byte boundaries
`timescale 1ns/1ps
module isp_link
   import isp_pkg::*;
(
   // link pins
   input  wire logic    sck,
   input  wire logic    reset_n,
   input  wire logic    mosi,
   output logic         miso,
   // core side
   input  isp_pkg::isp_tx_t tx,
   output isp_pkg::isp_rx_t rx
);
   typedef struct packed {
      logic [2:0] cnt;
      logic [6:0] sh;
      isp_rx_t    rx;
   } isp_link_t;

   isp_link_t  s, n;
   logic [7:0] out_q;

   always_comb
   begin
      n = s;
      n.sh = {s.sh[5:0], mosi};
      n.cnt = s.cnt + 3'h1;
      if (s.cnt == 3'h7)
      begin
         n.rx.data = {s.sh, mosi};
         n.rx.tgl = ~s.rx.tgl;
      end
   end

   // pin high clears framing at once, sck may never toggle during the pulse
   always_ff @(posedge sck or posedge reset_n)
   begin
      if (reset_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   // default reply echoes the byte just received, so the enable echo needs no core round trip
   always_ff @(negedge sck or posedge reset_n)
   begin
      if (reset_n)
      begin
         out_q <= '0;
      end
      else if (s.cnt == 3'h0)
      begin
         out_q <= tx.use_it ? tx.data : s.rx.data;
      end
      else
      begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   assign miso = out_q[7];
   assign rx   = s.rx;
endmodule

/* hdl/isp_core.sv */
// isp_core: serial in-system programming port, instruction decode, memories and busy timing
// assumes clk is the device clock and sck, mosi, reset_n come from an external programmer
`timescale 1ns/1ps
module isp_core #(
   parameter int FLASH_WAIT  = isp_pkg::FLASH_WAIT_CYC,
   parameter int EEPROM_WAIT = isp_pkg::EEPROM_WAIT_CYC
) (
   // device clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // programming link
   input  wire logic sck,
   input  wire logic reset_n,
   input  wire logic mosi,
   output logic      miso,
   // status
   output logic      prog_mode,
   output logic      busy
);
   import isp_pkg::*;

   isp_core_t             s, n;
   isp_rx_t               rx;
   logic                  ev;
   logic [7:0]            op;
   logic                  fl_we;
   logic [FLASH_AW-1:0]   fl_waddr;
   logic [7:0]            fl_wdata;
   logic [FLASH_AW-1:0]   fl_raddr;
   logic [7:0]            fl_rdata;
   logic                  ee_we;
   logic [EEPROM_AW-1:0]  ee_waddr;
   logic [7:0]            ee_wdata;
   logic [EEPROM_AW-1:0]  ee_raddr;
   logic [7:0]            ee_rdata;
   logic                  pb_we;
   logic [PAGE_AW-1:0]    pb_waddr;
   logic [7:0]            pb_wdata;
   logic [PAGE_AW-1:0]    pb_raddr;
   logic [7:0]            pb_rdata;

   // opcode with the high/low byte select masked off
   function automatic logic [7:0] base_op(input logic [7:0] b);
      base_op = b & ~(8'h01 << H_BIT);
   endfunction

   isp_link u_link (
      .sck     (sck),
      .reset_n (reset_n),
      .mosi    (mosi),
      .miso    (miso),
      .tx      (s.tx),
      .rx      (rx)
   );

   isp_mem #(.AW(FLASH_AW)) u_flash (
      .clk   (clk),
      .we    (fl_we),
      .waddr (fl_waddr),
      .wdata (fl_wdata),
      .raddr (fl_raddr),
      .rdata (fl_rdata)
   );

   isp_mem #(.AW(EEPROM_AW)) u_eeprom (
      .clk   (clk),
      .we    (ee_we),
      .waddr (ee_waddr),
      .wdata (ee_wdata),
      .raddr (ee_raddr),
      .rdata (ee_rdata)
   );

   isp_mem #(.AW(PAGE_AW)) u_page (
      .clk   (clk),
      .we    (pb_we),
      .waddr (pb_waddr),
      .wdata (pb_wdata),
      .raddr (pb_raddr),
      .rdata (pb_rdata)
   );

   // word address a:b plus byte select; eeprom keeps its own space
   assign fl_raddr = {s.b1[4:0], s.b2, s.b0[H_BIT]};
   assign ee_raddr = {s.b1[0], s.b2};
   assign pb_raddr = s.walk[PAGE_AW-1:0];
   assign op       = base_op(s.b0);

   always_comb
   begin
      n = s;
      ev = 1'b0;
      fl_we = 1'b0;
      fl_waddr = '0;
      fl_wdata = ERASED;
      ee_we = 1'b0;
      ee_waddr = '0;
      ee_wdata = ERASED;
      pb_we = 1'b0;
      pb_waddr = '0;
      pb_wdata = '0;

      // reset pin and byte toggle both cross from outside this clock
      n.rn_sync = {s.rn_sync[1:0], reset_n};
      if (s.rn_sync[1] == s.rn_sync[2])
      begin
         n.in_reset = s.rn_sync[2];
      end
      n.tg_sync = {s.tg_sync[1:0], rx.tgl};
      if (s.tg_sync[1] == s.tg_sync[2])
      begin
         n.tg_seen = s.tg_sync[2];
         // pin going high also clears the link toggle; that step is no byte
         ev = (s.tg_sync[2] != s.tg_seen) && !s.in_reset && !n.in_reset;
      end

      // self-timed work
      case (s.busy)
         B_ERASE:
         begin
            fl_we = 1'b1;
            fl_waddr = s.walk;
            ee_we = (s.walk[13:9] == EE_WALK_TOP);
            ee_waddr = s.walk[8:0];
            n.walk = s.walk + 14'h0001;
            if (s.walk == FLASH_LAST)
            begin
               n.busy = B_IDLE;
            end
         end
         B_COPY:
         begin
            // page buffer read is one cycle behind the walk
            if (s.walk != 14'h0000)
            begin
               fl_we = 1'b1;
               fl_waddr = {s.page, 7'(s.walk - 14'h0001)};
               fl_wdata = pb_rdata;
            end
            n.walk = s.walk + 14'h0001;
            n.timer = s.timer - 32'h0000_0001;
            if (s.walk == PAGE_BYTES)
            begin
               n.busy = B_FLASH;
            end
         end
         B_FLASH, B_EE:
         begin
            n.timer = s.timer - 32'h0000_0001;
            if (s.timer <= 32'h0000_0001)
            begin
               n.busy = B_IDLE;
            end
         end
         default:
         begin
            n.walk = '0;
         end
      endcase

      // read data lands two cycles after the address byte
      case (s.rd_stage)
         2'h1:
         begin
            n.rd_stage = 2'h2;
         end
         2'h2:
         begin
            n.tx.data = s.rd_ff ? ERASED : (s.rd_ee ? ee_rdata : fl_rdata);
            n.tx.use_it = 1'b1;
            n.rd_stage = 2'h0;
         end
         default:
         begin
            n.rd_stage = 2'h0;
         end
      endcase

      if (ev)
      begin
         n.tx.use_it = 1'b0;
         n.idx = s.idx + 2'h1;
         case (s.idx)
            2'h0:
            begin
               n.b0 = rx.data;
            end
            2'h1:
            begin
               n.b1 = rx.data;
            end
            2'h2:
            begin
               n.b2 = rx.data;
               if (s.prog_en && (base_op(s.b0) == OP_RD_FLASH || s.b0 == OP_RD_EE))
               begin
                  n.rd_stage = 2'h1;
                  n.rd_ee = (s.b0 == OP_RD_EE);
                  // polling a page or byte still in flight sees erased data
                  if (s.b0 == OP_RD_EE)
                  begin
                     n.rd_ff = (s.busy == B_EE) && ({s.b1[0], rx.data} == s.ee_addr);
                  end
                  else
                  begin
                     n.rd_ff = (s.busy == B_COPY || s.busy == B_FLASH)
                               && ({s.b1[4:0], rx.data[7:6]} == s.page);
                  end
               end
            end
            default:
            begin
               if (s.b0 == OP_ENABLE_B1 && s.b1 == ENABLE_B2)
               begin
                  n.prog_en = 1'b1;
               end
               else if (s.prog_en && s.busy == B_IDLE)
               begin
                  if (s.b0 == OP_ENABLE_B1 && s.b1[7:5] == ERASE_B2_TOP)
                  begin
                     n.busy = B_ERASE;
                     n.walk = '0;
                  end
                  else if (op == OP_LD_PAGE)
                  begin
                     pb_we = 1'b1;
                     pb_waddr = {s.b2[5:0], s.b0[H_BIT]};
                     pb_wdata = rx.data;
                  end
                  else if (s.b0 == OP_WR_PAGE)
                  begin
                     n.busy = B_COPY;
                     n.walk = '0;
                     n.page = {s.b1[4:0], s.b2[7:6]};
                     n.timer = 32'(FLASH_WAIT);
                  end
                  else if (s.b0 == OP_WR_EE)
                  begin
                     // a plain overwrite is the erase-then-write of one location
                     ee_we = 1'b1;
                     ee_waddr = {s.b1[0], s.b2};
                     ee_wdata = rx.data;
                     n.busy = B_EE;
                     n.ee_addr = {s.b1[0], s.b2};
                     n.timer = 32'(EEPROM_WAIT);
                  end
               end
            end
         endcase
      end

      // pin high drops the session and the framing
      if (s.in_reset)
      begin
         n.prog_en = 1'b0;
         n.idx = 2'h0;
         n.tx.use_it = 1'b0;
         n.rd_stage = 2'h0;
      end
      n.busy_o = (n.busy != B_IDLE);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '{rn_sync: 3'h7, in_reset: 1'b1, busy: B_IDLE, default: '0};
      end
      else
      begin
         s <= n;
      end
   end

   assign prog_mode = s.prog_en;
   assign busy      = s.busy_o;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence copy_run;
      (s.busy == B_COPY) [*8];
   endsequence

   sequence busy_hold;
      s.busy_o [*8];
   endsequence

   a_reset_drops_mode: assert property (s.in_reset |=> !s.prog_en && s.idx == 2'h0)
      else $error("programming mode kept while reset pin high");

   a_locked_no_write: assert property ((pb_we || s.busy == B_ERASE || ee_we) |-> s.prog_en || s.busy != B_IDLE)
      else $error("memory write without programming enable");

   a_ee_write_once: assert property (ee_we && s.busy == B_IDLE |=> s.busy == B_EE && s.timer == 32'(EEPROM_WAIT))
      else $error("eeprom write did not start its self timed cycle");

   a_erase_fill: assert property (s.busy == B_ERASE |-> fl_we && fl_wdata == ERASED && fl_waddr == s.walk)
      else $error("chip erase wrote a value other than ff");

   a_erase_ee_part: assert property (s.busy == B_ERASE && s.walk < 14'h0200 |-> ee_we && ee_wdata == ERASED)
      else $error("chip erase skipped an eeprom location");

   a_page_load_addr: assert property (pb_we |-> pb_waddr == {s.b2[5:0], s.b0[H_BIT]} && s.idx == 2'h3)
      else $error("page buffer byte at wrong position");

   a_page_commit: assert property ($rose(s.busy == B_COPY) |-> copy_run ##0 (fl_waddr[13:7] == s.page))
      else $error("page commit ended early or wrote outside the page");

   a_page_busy: assert property ($rose(s.busy == B_COPY) |-> busy_hold)
      else $error("busy flag dropped during page programming");

   a_poll_ff: assert property (s.rd_stage == 2'h2 && s.rd_ff |=> s.tx.data == ERASED && s.tx.use_it)
      else $error("busy page polled without ff");

   a_read_reply: assert property (s.rd_stage == 2'h2 && !s.rd_ff && !s.rd_ee |=> s.tx.data == $past(fl_rdata))
      else $error("flash read reply does not match memory");

   a_enable_code: assert property ($rose(s.prog_en) |-> $past(s.b0) == OP_ENABLE_B1 && $past(s.b1) == ENABLE_B2)
      else $error("programming enabled by wrong instruction");

   a_read_timing: assert property (ev && s.idx == 2'h2 && s.prog_en && s.b0 == OP_RD_EE |=> ##1 s.rd_stage == 2'h2)
      else $error("read reply not prepared on time");
endmodule

/* sim/isp_prog_model.sv */
// isp_prog_model: behavioural in-system programmer driving the serial pins
// assumes the device samples mosi on sck rise and shifts miso on sck fall
`timescale 1ns/1ps
module isp_prog_model #(
   parameter int HALF_NS = 320,
   parameter int GAP_NS  = 1000,
   parameter int WAIT_NS = 2000
) (
   // link pins
   output logic      sck,
   output logic      reset_n,
   output logic      mosi,
   input  wire logic miso
);
   initial
   begin
      sck     = 1'b0;
      reset_n = 1'b0;
      mosi    = 1'b0;
   end

   // data set while sck low, reply taken before the rising edge; hi is the high phase
   task automatic bit_x(input logic b, input int hi, output logic r);
      begin
         mosi = b;
         #(HALF_NS);
         r   = miso;
         sck = 1'b1;
         #(hi);
         sck = 1'b0;
      end
   endtask

   task automatic xfer(input logic [31:0] ins, output logic [31:0] rsp);
      logic r;
      begin
         for (int i = 31; i >= 0; i--)
         begin
            // long high on a byte's last bit: the next reply is loaded at that fall
            bit_x(ins[i], (i % 8 == 0) ? GAP_NS : HALF_NS, r);
            rsp[i] = r;
            if (i % 8 == 0)
            begin
               // released data line must not look like a held bit
               mosi = ~ins[i];
               #(GAP_NS);
            end
         end
      end
   endtask

   task automatic partial(input int n);
      logic r;
      begin
         for (int i = 0; i < n; i++)
            bit_x(1'b1, HALF_NS, r);
         #(GAP_NS);
      end
   endtask

   task automatic settle;
      begin
         #(WAIT_NS);
      end
   endtask

   task automatic resync;
      begin
         reset_n = 1'b1;
         #(GAP_NS);
         reset_n = 1'b0;
         settle();
      end
   endtask

   task automatic leave;
      begin
         reset_n = 1'b1;
      end
   endtask
endmodule

/* sim/testbench.sv */
// testbench: self-checking run of the serial programming port against the programmer model
// assumes shortened flash and eeprom wait parameters; link traffic timed by the model
`timescale 1ns/1ps
module testbench;
   import isp_pkg::*;
   localparam int FW = 2000;
   localparam int EW = 400;

   typedef struct packed {
      logic [31:0] ins;
      logic        chk;
      logic [7:0]  exp;
   } isp_row_t;

   localparam isp_row_t ROWS [17] = '{
      '{32'h2000_0000, 1'b1, 8'hFF},
      '{32'h201F_FF00, 1'b1, 8'hFF},
      '{32'hA001_FF00, 1'b1, 8'hFF},
      '{32'hC001_FF5A, 1'b0, 8'h00},
      '{32'hA001_FF00, 1'b1, 8'h5A},
      '{32'hA000_FF00, 1'b1, 8'hFF},
      '{32'hC001_FF3C, 1'b0, 8'h00},
      '{32'hA001_FF00, 1'b1, 8'h3C},
      '{32'h4000_0011, 1'b0, 8'h00},
      '{32'h4800_0022, 1'b0, 8'h00},
      '{32'h4000_3F33, 1'b0, 8'h00},
      '{32'h4C1F_C000, 1'b0, 8'h00},
      '{32'h201F_C000, 1'b1, 8'h11},
      '{32'h281F_C000, 1'b1, 8'h22},
      '{32'h201F_FF00, 1'b1, 8'h33},
      '{32'h2000_0000, 1'b1, 8'hFF},
      '{32'hA000_0000, 1'b1, 8'hFF}
   };

   logic        clk;
   logic        rst;
   logic        sck;
   logic        reset_n;
   logic        mosi;
   logic        miso;
   logic        prog_mode;
   logic        busy;
   logic [31:0] rsp;
   int          n;
   int          errors;
   int          total_checks;

   isp_core #(.FLASH_WAIT(FW), .EEPROM_WAIT(EW)) uut (
      .clk       (clk),
      .rst       (rst),
      .sck       (sck),
      .reset_n   (reset_n),
      .mosi      (mosi),
      .miso      (miso),
      .prog_mode (prog_mode),
      .busy      (busy)
   );

   isp_prog_model prog (
      .sck     (sck),
      .reset_n (reset_n),
      .mosi    (mosi),
      .miso    (miso)
   );

   initial
   begin
      clk = 1'b0;
   end

   always #50 clk = ~clk;

   task automatic end_sim;
      begin
         $display("checks %0d errors %0d", total_checks, errors);
         if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      begin
         total_checks++;
         if (got !== exp)
         begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
         end
      end
   endtask

   // bounded wait for the busy level to drop, returns cycles seen high
   task automatic wait_idle(output int cnt);
      begin
         cnt = 0;
         while (busy !== 1'b0 && cnt < 40000)
         begin
            @(negedge clk);
            cnt++;
         end
         if (cnt >= 40000)
         begin
            errors++;
            $display("mismatch at %0t: busy never dropped", $time);
            end_sim();
         end
      end
   endtask

   task automatic wait_mode(input logic m);
      begin
         for (int i = 0; i < 20 && prog_mode !== m; i++)
            @(negedge clk);
         check({7'h00, prog_mode}, {7'h00, m}, "prog_mode");
      end
   endtask

   initial
   begin
      rst          = 1'b1;
      errors       = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({6'h00, prog_mode, busy}, 8'h00, "after reset");
      prog.settle();
      // stray bits then a reset pulse: framing must restart
      prog.partial(3);
      prog.resync();
      prog.xfer(32'hAC80_0000, rsp);
      repeat (10) @(negedge clk);
      check({6'h00, prog_mode, busy}, 8'h00, "erase before enable");
      prog.xfer(32'hAC53_0000, rsp);
      check(rsp[15:8], 8'h53, "enable echo");
      wait_mode(1'b1);
      prog.xfer(32'hAC80_0000, rsp);
      @(negedge clk);
      check({7'h00, busy}, 8'h01, "erase busy");
      wait_idle(n);
      prog.resync();
      prog.xfer(32'hAC53_0000, rsp);
      wait_mode(1'b1);
      for (int k = 0; k < 17; k++)
      begin
         prog.xfer(ROWS[k].ins, rsp);
         if (ROWS[k].chk)
            check(rsp[7:0], ROWS[k].exp, "row read");
         wait_idle(n);
      end
      prog.xfer(32'hC000_1077, rsp);
      wait_idle(n);
      check({7'h00, (n > EW / 2 && n <= EW)}, 8'h01, "eeprom busy time");
      // poll a page while it programs; writes meanwhile are dropped
      prog.xfer(32'h4000_0044, rsp);
      prog.xfer(32'h4C00_0000, rsp);
      prog.xfer(32'h2000_0000, rsp);
      check(rsp[7:0], 8'hFF, "busy page poll");
      prog.xfer(32'hC000_1099, rsp);
      check({7'h00, busy}, 8'h01, "page still busy");
      wait_idle(n);
      prog.xfer(32'h2000_0000, rsp);
      check(rsp[7:0], 8'h44, "page done poll");
      prog.xfer(32'hA000_1000, rsp);
      check(rsp[7:0], 8'h77, "write during busy");
      prog.leave();
      wait_mode(1'b0);
      check({7'h00, miso}, 8'h00, "miso idle");
      end_sim();
   end
endmodule
